/* design/pmp_pkg.sv */
/*
 * Shared types and constants of the parallel media-independent port:
 * interface modes, control layout, register offsets, timing counts.
 * Assumes a single 10 MHz system clock that oversamples the link clocks.
 */
package pmp_pkg;

   // ----------------------------------------------------------------
   // Modes and carriers
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      PMP_MII       = 3'h0,
      PMP_GMII      = 3'h1,
      PMP_RGMII10   = 3'h2,
      PMP_RGMII100  = 3'h3,
      PMP_RGMII1000 = 3'h4,
      PMP_TBI       = 3'h5,
      PMP_REDUCED_TEN_BIT_MODE      = 3'h6
   } pmp_mode_t;

   typedef struct packed
   {
      logic      half_duplex;
      logic      collision_test;
      logic      datapath_loopback;
      logic      tx_clock_output_enable;
      logic      tbi_two_clock_select;
      logic      terminal_role_select;
      pmp_mode_t mode;
   } pmp_ctrl_t;

   typedef struct packed
   {
      logic [9:0] code;
      logic       dv;
      logic       er;
   } pmp_rx_word_t;

   typedef struct packed
   {
      logic [9:0] code;
      logic       en;
      logic       er;
   } pmp_tx_word_t;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0]  PMP_ADDR_CTRL  = 4'h0;
   localparam logic [3:0]  PMP_ADDR_STAT  = 4'h4;
   localparam logic [3:0]  PMP_ADDR_GPIO  = 4'h8;
   localparam logic [3:0]  PMP_ADDR_PINS  = 4'hC;
   localparam logic [8:0]  PMP_CTRL_RST   = 9'h019;
   localparam int          PMP_GPIO_OE_LSB = 8;
   localparam logic [5:0]  PMP_GPIO_RST   = 6'h00;
   localparam logic [6:0]  PMP_COMMA_POS  = 7'h7C;
   localparam logic [6:0]  PMP_COMMA_NEG  = 7'h03;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int PMP_CLK_PERIOD_NS  = 100;
   localparam int PMP_LINK_PERIOD_NS = 800;
   localparam int PMP_LINK_HALF_CYC  = (PMP_LINK_PERIOD_NS / (2 * PMP_CLK_PERIOD_NS) < 1) ? 1 :
                                       PMP_LINK_PERIOD_NS / (2 * PMP_CLK_PERIOD_NS);

   // ----------------------------------------------------------------
   // Decoders
   // ----------------------------------------------------------------
   function automatic logic pmp_is_rgmii(input pmp_mode_t m);
      pmp_is_rgmii = (m == PMP_RGMII10) || (m == PMP_RGMII100) || (m == PMP_RGMII1000);
   endfunction : pmp_is_rgmii

   function automatic logic pmp_is_ten_bit(input pmp_mode_t m);
      pmp_is_ten_bit = (m == PMP_TBI) || (m == PMP_REDUCED_TEN_BIT_MODE);
   endfunction : pmp_is_ten_bit

   // Four-bit receive bus; upper transmit lines free as shared pins
   function automatic logic pmp_is_narrow(input pmp_mode_t m);
      pmp_is_narrow = (m == PMP_MII) || pmp_is_rgmii(m) || (m == PMP_REDUCED_TEN_BIT_MODE);
   endfunction : pmp_is_narrow

   function automatic logic pmp_comma_hit(input logic [9:0] c);
      pmp_comma_hit = (c[6:0] == PMP_COMMA_POS) || (c[6:0] == PMP_COMMA_NEG);
   endfunction : pmp_comma_hit

endpackage : pmp_pkg

/* design/pmp_port.sv */
// Behaviour
// - GMII launches eight receive bits, valid and error on receive clock rise.
// - MII and slow RGMII launch a low nibble on rise; upper lines float.
// - RGMII-1000 sends low nibble on rise, high nibble on fall; upper lines float.
// - Terminal role takes link clocks in; communication role drives them out.
// - Normal ten-bit mode puts bits 7..0, 8 and 9 on data, valid, error.
// - Two-clock ten-bit mode times odd groups on primary, even on secondary.
// - One-clock ten-bit mode launches whole groups on single clock rise.
// - Reduced ten-bit sends bits 3..0,4 on rise and 8..5,9 on fall.
// - All RGMII modes carry receive control on valid pin at both edges.
// - Error pin floats in RGMII and reduced; collision floats in ten-bit modes.
// - Collision is asynchronous, forced low in loopback unless collision test.
// - Carrier sense is asynchronous, high when transmit or receive path active.
// - Ten-bit modes reuse carrier sense as comma flag updated on rise, and also on fall in two-clock mode.
// - Transmit clock pin outputs a clock when its output enable is set outside MII; MII drives it in communication role only, regardless of enable.
// - Two-clock ten-bit mode turns transmit clock pin into secondary receive clock.
// - GMII captures eight data bits, enable and error on GTX clock rise.
// - MII and slow RGMII capture low nibble on transmit or GTX clock rise.
// - RGMII-1000 captures low nibble on rise and high nibble on fall.
// - Ten-bit mode captures bits 7..0, 8 from enable, 9 from error.
// - Reduced ten-bit captures 3..0,4 on rise and 8..5,9 on fall.
// - RGMII samples control on both edges and ignores transmit error pin.
// - Upper transmit lines double as shared pins; shared pins float after reset.
/*
 * Parallel port of an Ethernet interface converter: receive launch, transmit
 * capture, carrier and collision pins, link clock outputs and shared pins.
 * Assumes link clocks slow enough to be oversampled by I_CLK, a register
 * master on I_CLK, and a receive word source that reloads on O_RX_TAKE.
 */
module pmp_port
   import pmp_pkg::*;
#(
   parameter int DIV_HALF = PMP_LINK_HALF_CYC
)
(
   // Clock and reset
   input  wire logic         I_CLK,
   input  wire logic         I_RESET,
   // Register port
   input  wire logic [3:0]   I_ADDR,
   input  wire logic [31:0]  I_WDATA,
   input  wire logic         I_WR,
   input  wire logic         I_RD,
   output logic      [31:0]  O_RDATA,
   // Receive word source and path activity
   input  wire pmp_rx_word_t I_RX_WORD,
   input  wire logic         I_RX_ACTIVE,
   output logic              O_RX_TAKE,
   // Captured transmit words
   output pmp_tx_word_t      O_TX_WORD,
   output logic              O_TX_VALID,
   // Receive pins
   input  wire logic         I_RXCLK,
   output logic              O_RXCLK,
   output logic              O_RXCLK_OE,
   output logic      [7:0]   O_RXD,
   output logic      [7:0]   O_RXD_OE,
   output logic              O_RX_DV,
   output logic              O_RX_DV_OE,
   output logic              O_RX_ER,
   output logic              O_RX_ER_OE,
   output logic              O_COL,
   output logic              O_COL_OE,
   output logic              O_CRS,
   output logic              O_CRS_OE,
   // Transmit pins
   input  wire logic         I_TXCLK,
   output logic              O_TXCLK,
   output logic              O_TXCLK_OE,
   input  wire logic         I_GTXCLK,
   input  wire logic [7:0]   I_TXD,
   input  wire logic         I_TX_EN,
   input  wire logic         I_TX_ER,
   // Shared pins 2..7, outputs for 4..7 share the upper transmit lines
   input  wire logic [1:0]   I_SHARED_IO_23,
   output logic      [5:0]   O_SHARED_IO,
   output logic      [5:0]   O_SHARED_IO_OE
);

   // ----------------------------------------------------------------
   // Registers and synchronisers
   // ----------------------------------------------------------------
   pmp_ctrl_t    ctrl_r;
   logic [5:0]   gpio_out_r;
   logic [5:0]   gpio_oe_r;
   logic [31:0]  rdata_r;
   logic         out_en_r;
   logic [14:0]  sync1_r;
   logic [14:0]  sync2_r;
   logic [15:0]  div_cnt_r;
   logic         div_clk_r;
   logic         rx_prev_r;
   logic         tx_prev_r;
   pmp_rx_word_t hold_r;
   logic [7:0]   rxd_r;
   logic         rx_dv_r;
   logic         rx_er_r;
   logic         comma_r;
   pmp_tx_word_t tx_r;
   logic         tx_valid_r;
   logic         rx_lvl;
   logic         tx_lvl;
   logic         rx_rise;
   logic         rx_fall;
   logic         tx_rise;
   logic         tx_fall;
   logic         rxclk_s;
   logic         txclk_s;
   logic         gtxclk_s;
   logic [7:0]   txd_s;
   logic         tx_en_s;
   logic         tx_er_s;
   logic [1:0]   io23_s;
   logic         mii_family;
   logic         tx_active;
   pmp_mode_t    mode;

   assign mode       = ctrl_r.mode;
   assign mii_family = !pmp_is_ten_bit(mode);
   assign tx_active  = tx_r.en;

   // Pins from outside the clock domain pass two flops
   always_ff @(posedge I_CLK)
   begin
      sync1_r <= {I_SHARED_IO_23, I_TX_ER, I_TX_EN, I_TXD, I_GTXCLK, I_TXCLK, I_RXCLK};
      sync2_r <= sync1_r;
   end
   assign rxclk_s  = sync2_r[0];
   assign txclk_s  = sync2_r[1];
   assign gtxclk_s = sync2_r[2];
   assign txd_s    = sync2_r[10:3];
   assign tx_en_s  = sync2_r[11];
   assign tx_er_s  = sync2_r[12];
   assign io23_s   = sync2_r[14:13];

   // ----------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         ctrl_r     <= pmp_ctrl_t'(PMP_CTRL_RST);
         gpio_out_r <= PMP_GPIO_RST;
         gpio_oe_r  <= PMP_GPIO_RST;
      end
      else if (I_WR && I_ADDR == PMP_ADDR_CTRL)
         ctrl_r <= pmp_ctrl_t'(I_WDATA[8:0]);
      else if (I_WR && I_ADDR == PMP_ADDR_GPIO)
      begin
         gpio_out_r <= I_WDATA[5:0];
         gpio_oe_r  <= I_WDATA[PMP_GPIO_OE_LSB +: 6];
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET || !I_RD)
         rdata_r <= 32'h0000_0000;
      else
         case (I_ADDR)
            PMP_ADDR_CTRL: rdata_r <= {23'h00_0000, ctrl_r};
            PMP_ADDR_STAT: rdata_r <= {17'h0_0000, comma_r, I_RX_ACTIVE, tx_active, tx_r};
            PMP_ADDR_GPIO: rdata_r <= {18'h0_0000, gpio_oe_r, 2'h0, gpio_out_r};
            PMP_ADDR_PINS: rdata_r <= {24'h00_0000, txd_s[7:4], tx_er_s, tx_en_s, io23_s};
            default:       rdata_r <= 32'h0000_0000;
         endcase
   end
   assign O_RDATA = rdata_r;

   // Pins stay undriven until reset has been released
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
         out_en_r <= 1'b0;
      else
         out_en_r <= 1'b1;
   end

   // ----------------------------------------------------------------
   // Link clocks
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         div_cnt_r <= 16'h0000;
         div_clk_r <= 1'b0;
      end
      else if (div_cnt_r == 16'(DIV_HALF - 1))
      begin
         div_cnt_r <= 16'h0000;
         div_clk_r <= ~div_clk_r;
      end
      else
         div_cnt_r <= div_cnt_r + 16'h0001;
   end

   assign rx_lvl = ctrl_r.terminal_role_select ? rxclk_s : div_clk_r;
   assign tx_lvl = (mode != PMP_MII) ? gtxclk_s :
                   (ctrl_r.terminal_role_select ? txclk_s : div_clk_r);

   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         rx_prev_r <= 1'b0;
         tx_prev_r <= 1'b0;
      end
      else
      begin
         rx_prev_r <= rx_lvl;
         tx_prev_r <= tx_lvl;
      end
   end
   assign rx_rise = rx_lvl & ~rx_prev_r & out_en_r;
   assign rx_fall = ~rx_lvl & rx_prev_r & out_en_r;
   assign tx_rise = tx_lvl & ~tx_prev_r & out_en_r;
   assign tx_fall = ~tx_lvl & tx_prev_r & out_en_r;

   // clock driven out only in communication role
   assign O_RXCLK    = div_clk_r;
   assign O_RXCLK_OE = out_en_r & ~ctrl_r.terminal_role_select;

   // Secondary clock is the inverse of the primary, so even groups land on its rise
   always_comb
   begin
      O_TXCLK    = div_clk_r;
      O_TXCLK_OE = 1'b0;
      if (mode == PMP_MII)
         O_TXCLK_OE = out_en_r & ~ctrl_r.terminal_role_select;
      else if (mode == PMP_TBI && ctrl_r.tbi_two_clock_select)
      begin
         O_TXCLK    = ~rx_lvl;
         O_TXCLK_OE = out_en_r;
      end
      else
         O_TXCLK_OE = out_en_r & ctrl_r.tx_clock_output_enable;
   end

   // ----------------------------------------------------------------
   // Receive launch
   // ----------------------------------------------------------------
   // two-clock mode also takes a word on the secondary rise
   assign O_RX_TAKE = rx_rise |
                      (rx_fall & (mode == PMP_TBI) & ctrl_r.tbi_two_clock_select);

   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         hold_r  <= '0;
         rxd_r   <= 8'h00;
         rx_dv_r <= 1'b0;
         rx_er_r <= 1'b0;
         comma_r <= 1'b0;
      end
      else if (rx_rise)
      begin
         hold_r <= I_RX_WORD;
         case (mode)
            PMP_GMII, PMP_MII:
            begin
               rxd_r   <= (mode == PMP_GMII) ? I_RX_WORD.code[7:0]
                                             : {4'h0, I_RX_WORD.code[3:0]};
               rx_dv_r <= I_RX_WORD.dv;
               rx_er_r <= I_RX_WORD.er;
            end
            // low nibble and control on rise
            PMP_RGMII10, PMP_RGMII100, PMP_RGMII1000:
            begin
               rxd_r   <= {4'h0, I_RX_WORD.code[3:0]};
               rx_dv_r <= I_RX_WORD.dv;
            end
            // whole group split over data, valid, error
            // one-clock mode launches on this rise only
            PMP_TBI:
            begin
               rxd_r   <= I_RX_WORD.code[7:0];
               rx_dv_r <= I_RX_WORD.code[8];
               rx_er_r <= I_RX_WORD.code[9];
               comma_r <= pmp_comma_hit(I_RX_WORD.code);
            end
            PMP_REDUCED_TEN_BIT_MODE:
            begin
               rxd_r   <= {4'h0, I_RX_WORD.code[3:0]};
               rx_dv_r <= I_RX_WORD.code[4];
               comma_r <= pmp_comma_hit(I_RX_WORD.code);
            end
            default:
               rxd_r <= rxd_r;
         endcase
      end
      else if (rx_fall)
      begin
         case (mode)
            // control on falling edge is valid xor error
            PMP_RGMII10, PMP_RGMII100:
               rx_dv_r <= hold_r.dv ^ hold_r.er;
            PMP_RGMII1000:
            begin
               rxd_r   <= {4'h0, hold_r.code[7:4]};
               rx_dv_r <= hold_r.dv ^ hold_r.er;
            end
            // even group on secondary clock rise
            PMP_TBI:
               if (ctrl_r.tbi_two_clock_select)
               begin
                  rxd_r   <= I_RX_WORD.code[7:0];
                  rx_dv_r <= I_RX_WORD.code[8];
                  rx_er_r <= I_RX_WORD.code[9];
                  comma_r <= pmp_comma_hit(I_RX_WORD.code);
               end
            PMP_REDUCED_TEN_BIT_MODE:
            begin
               rxd_r   <= {4'h0, hold_r.code[8:5]};
               rx_dv_r <= hold_r.code[9];
            end
            default:
               rxd_r <= rxd_r;
         endcase
      end
   end

   assign O_RXD   = rxd_r;
   assign O_RX_DV = rx_dv_r;
   assign O_RX_ER = rx_er_r;

   // upper lines float in narrow modes
   assign O_RXD_OE   = {{4{out_en_r & ~pmp_is_narrow(mode)}}, {4{out_en_r}}};
   assign O_RX_DV_OE = out_en_r;
   assign O_RX_ER_OE = out_en_r & ~pmp_is_rgmii(mode) & (mode != PMP_REDUCED_TEN_BIT_MODE);
   assign O_COL_OE   = out_en_r & mii_family;
   assign O_CRS_OE   = out_en_r;

   assign O_COL = ctrl_r.datapath_loopback ? (ctrl_r.collision_test & tx_active)
                                           : (ctrl_r.half_duplex & tx_active & I_RX_ACTIVE);
   // carrier; comma flag in ten-bit modes
   assign O_CRS = mii_family ? (tx_active | I_RX_ACTIVE) : comma_r;

   // ----------------------------------------------------------------
   // Transmit capture
   // ----------------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (I_RESET)
      begin
         tx_r       <= '0;
         tx_valid_r <= 1'b0;
      end
      else
      begin
         tx_valid_r <= 1'b0;
         if (tx_rise)
            case (mode)
               PMP_GMII:
               begin
                  tx_r       <= '{code: {2'h0, txd_s}, en: tx_en_s, er: tx_er_s};
                  tx_valid_r <= 1'b1;
               end
               PMP_MII:
               begin
                  tx_r       <= '{code: {6'h00, txd_s[3:0]}, en: tx_en_s, er: tx_er_s};
                  tx_valid_r <= 1'b1;
               end
               // control on rise, error pin ignored
               PMP_RGMII10, PMP_RGMII100, PMP_RGMII1000:
               begin
                  tx_r.code <= {6'h00, txd_s[3:0]};
                  tx_r.en   <= tx_en_s;
               end
               PMP_TBI:
               begin
                  tx_r       <= '{code: {tx_er_s, tx_en_s, txd_s}, en: 1'b0, er: 1'b0};
                  tx_valid_r <= 1'b1;
               end
               PMP_REDUCED_TEN_BIT_MODE:
                  tx_r.code[4:0] <= {tx_en_s, txd_s[3:0]};
               default:
                  tx_r <= tx_r;
            endcase
         else if (tx_fall)
            case (mode)
               // falling control is enable xor error
               PMP_RGMII10, PMP_RGMII100:
               begin
                  tx_r.er    <= tx_en_s ^ tx_r.en;
                  tx_valid_r <= 1'b1;
               end
               PMP_RGMII1000:
               begin
                  tx_r.code[7:4] <= txd_s[3:0];
                  tx_r.er        <= tx_en_s ^ tx_r.en;
                  tx_valid_r     <= 1'b1;
               end
               PMP_REDUCED_TEN_BIT_MODE:
               begin
                  tx_r.code[9:5] <= {tx_en_s, txd_s[3:0]};
                  tx_valid_r     <= 1'b1;
               end
               default:
                  tx_r <= tx_r;
            endcase
      end
   end

   assign O_TX_WORD  = tx_r;
   assign O_TX_VALID = tx_valid_r;

   // ----------------------------------------------------------------
   // Shared pins
   // ----------------------------------------------------------------
   // upper lines usable only in narrow modes, floating after reset
   assign O_SHARED_IO    = gpio_out_r;
   assign O_SHARED_IO_OE = {gpio_oe_r[5:2] & {4{pmp_is_narrow(mode)}}, gpio_oe_r[1:0]};

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);

   a_gmii_rx_octet: assert property (
      rx_rise && mode == PMP_GMII |=> O_RXD == $past(I_RX_WORD.code[7:0]) && O_RX_DV_OE)
      else $error("GMII octet not launched");
   a_narrow_upper_float: assert property (
      pmp_is_narrow(mode) |-> O_RXD_OE[7:4] == 4'h0)
      else $error("Upper receive lines driven in narrow mode");
   a_rgmii_high_nibble: assert property (
      rx_fall && mode == PMP_RGMII1000 |=> O_RXD[3:0] == $past(hold_r.code[7:4]))
      else $error("High nibble missing on falling edge");
   a_dce_clock_out: assert property (
      out_en_r && !ctrl_r.terminal_role_select |-> O_RXCLK_OE)
      else $error("Receive clock not driven in communication role");
   a_tbi_group_split: assert property (
      rx_rise && mode == PMP_TBI |=> {O_RX_ER, O_RX_DV, O_RXD} == $past(I_RX_WORD.code))
      else $error("Ten-bit group split wrong");
   a_reduced_ten_bit_mode_second_half: assert property (
      rx_fall && mode == PMP_REDUCED_TEN_BIT_MODE |=> {O_RX_DV, O_RXD[3:0]} == $past(hold_r.code[9:5]))
      else $error("Reduced ten-bit second half wrong");
   a_error_pin_float: assert property (
      pmp_is_rgmii(mode) || mode == PMP_REDUCED_TEN_BIT_MODE |-> !O_RX_ER_OE)
      else $error("Error pin driven in double-rate mode");
   a_loopback_col_low: assert property (
      ctrl_r.datapath_loopback && !ctrl_r.collision_test |-> !O_COL)
      else $error("Collision not forced low in loopback");
   a_carrier_follows: assert property (
      mii_family && (tx_active || I_RX_ACTIVE) |-> O_CRS)
      else $error("Carrier sense missing");
   a_gmii_tx_capture: assert property (
      tx_rise && mode == PMP_GMII |=> O_TX_VALID && O_TX_WORD.code[7:0] == $past(txd_s))
      else $error("GMII transmit octet not captured");
   a_shared_reset_float: assert property (
      @(posedge I_CLK) disable iff (1'b0) I_RESET |=> O_SHARED_IO_OE == 6'h00)
      else $error("Shared pins driven after reset");

   c_gmii_frame:  cover property (mode == PMP_GMII && O_TX_VALID && O_TX_WORD.en);
   c_tbi_two_clk: cover property (mode == PMP_TBI && ctrl_r.tbi_two_clock_select && rx_fall);
   c_rgmii_fall:  cover property (mode == PMP_RGMII1000 && rx_fall);
   c_collision:   cover property (O_COL && O_COL_OE);

endmodule : pmp_port

/* bench/pmp_mac_model.sv */
/*
 * MAC-side model: makes the GTX clock and presents the transmit pins.
 * Assumes the testbench loads the code group to send on i_code.
 */
module pmp_mac_model
(
   // Word to send
   input  wire logic [9:0] i_code,
   // Pins toward the port
   output logic            o_gtxclk,
   output logic      [7:0] o_txd,
   output logic            o_tx_en,
   output logic            o_tx_er
);
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------------------------------
   // Clock and launch
   // ----------------------------------------------------------------
   initial o_gtxclk = 1'b1;
   always #400 o_gtxclk = ~o_gtxclk;

   // launch on fall
   // Launching half a period early keeps data still around the capture rise
   always @(negedge o_gtxclk)
   begin
      {o_tx_er, o_tx_en, o_txd} <= i_code;
   end
endmodule : pmp_mac_model

/* bench/testbench.sv */
/*
 * Testbench of the parallel port: register, mode, transmit and receive.
 * Assumes the MAC model drives the GTX clock and transmit pins; other clock inputs are tied.
 */
module testbench
   import pmp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   // Per-mode expectations, bit index is the mode code
   localparam logic [6:0] NARROW = 7'h5D;
   localparam logic [6:0] ER_ON  = 7'h23;
   localparam logic [6:0] COL_ON = 7'h1F;
   logic         clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, rx_act = 1'b0;
   logic [3:0]   addr = 4'h0;
   logic [31:0]  wdata = 32'h0000_0000, rdata;
   pmp_rx_word_t rx_word = '0;
   pmp_tx_word_t tx_word;
   logic [9:0]   tx_code = 10'h000;
   logic [7:0]   rxd, rxd_oe, txd;
   logic [5:0]   sh_oe, sh_io;
   logic         take, tx_valid, dv, er, er_oe, col, col_oe, crs, rxclk_oe, txclk_oe;
   logic         gtx, tx_en, tx_er;
   int           checks = 0, mismatches = 0, cyc = 0;

   always #50 clk = ~clk;

   pmp_port u_pmp_port
   (
      .I_CLK(clk), .I_RESET(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s),
      .I_RD(rd_s), .O_RDATA(rdata), .I_RX_WORD(rx_word), .I_RX_ACTIVE(rx_act),
      .O_RX_TAKE(take), .O_TX_WORD(tx_word), .O_TX_VALID(tx_valid),
      .I_RXCLK(1'b0), .O_RXCLK(), .O_RXCLK_OE(rxclk_oe), .O_RXD(rxd),
      .O_RXD_OE(rxd_oe), .O_RX_DV(dv), .O_RX_DV_OE(), .O_RX_ER(er),
      .O_RX_ER_OE(er_oe), .O_COL(col), .O_COL_OE(col_oe), .O_CRS(crs),
      .O_CRS_OE(), .I_TXCLK(1'b0), .O_TXCLK(), .O_TXCLK_OE(txclk_oe),
      .I_GTXCLK(gtx), .I_TXD(txd), .I_TX_EN(tx_en), .I_TX_ER(tx_er),
      .I_SHARED_IO_23(2'h0), .O_SHARED_IO(sh_io), .O_SHARED_IO_OE(sh_oe)
   );

   pmp_mac_model u_pmp_mac_model
   (
      .i_code(tx_code), .o_gtxclk(gtx), .o_txd(txd), .o_tx_en(tx_en), .o_tx_er(tx_er)
   );

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
      @(posedge clk);
      #1;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
   endtask : rd

   // Bounded wait for a take pulse or a transmit word
   task automatic wait_on(input bit tx);
      for (int n = 0; n < 60; n++)
      begin
         @(posedge clk);
         #1;
         if (tx ? tx_valid === 1'b1 : take === 1'b1)
            return;
      end
      chk(32'h0000_0000, 32'h0000_0001);
   endtask : wait_on

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      logic [31:0] d;
      rd(PMP_ADDR_CTRL, d);
      chk(d, 32'h0000_0019);
      chk(sh_oe, 32'h0000_0000);
      chk(rxclk_oe, 32'h0000_0000);
      wr(4'h2, 32'hFFFF_FFFF);
      rd(4'h2, d);
      chk(d, 32'h0000_0000);
   endtask : t_reset

   task automatic t_modes;
      wr(PMP_ADDR_GPIO, 32'h0000_3F15);
      chk(sh_io, 6'h15);
      for (int m = 0; m < 7; m++)
      begin
         wr(PMP_ADDR_CTRL, 32'h0000_0018 | m);
         chk(rxd_oe, NARROW[m] ? 8'h0F : 8'hFF);
         chk(er_oe, ER_ON[m]);
         chk(col_oe, COL_ON[m]);
         chk(sh_oe[5:2], NARROW[m] ? 4'hF : 4'h0);
      end
      wr(PMP_ADDR_CTRL, 32'h0000_0005);
      chk(txclk_oe, 1'b0);
      wr(PMP_ADDR_CTRL, 32'h0000_0025);
      chk(txclk_oe, 1'b1);
   endtask : t_modes

   task automatic t_tx;
      wr(PMP_ADDR_CTRL, 32'h0000_0019);
      tx_code <= 10'h1A5;
      repeat (3) wait_on(1'b1);
      chk(tx_word.code[7:0], 8'hA5);
      chk(tx_word.en, 1'b1);
      wr(PMP_ADDR_CTRL, 32'h0000_001D);
      tx_code <= 10'h2C3;
      repeat (3) wait_on(1'b1);
      chk(tx_word.code, 10'h2C3);
   endtask : t_tx

   task automatic t_rx;
      rx_word <= '{code: 10'h17C, dv: 1'b1, er: 1'b0};
      wr(PMP_ADDR_CTRL, 32'h0000_0011);
      wait_on(1'b0);
      @(posedge clk);
      #1;
      chk(rxd, 8'h7C);
      chk(dv, 1'b1);
      chk(rxclk_oe, 1'b1);
      wr(PMP_ADDR_CTRL, 32'h0000_0015);
      wait_on(1'b0);
      @(posedge clk);
      #1;
      chk({er, dv, rxd}, 10'h17C);
      chk(crs, 1'b1);
      chk(txclk_oe, 1'b1);
   endtask : t_rx

   task automatic t_ddr;
      rx_word <= '{code: 10'h2B6, dv: 1'b1, er: 1'b1};
      for (int m = 4; m < 7; m += 2)
      begin
         wr(PMP_ADDR_CTRL, 32'h0000_0010 | m);
         wait_on(1'b0);
         @(posedge clk);
         #1;
         chk({dv, rxd}, 9'h106);
         repeat (PMP_LINK_HALF_CYC) @(posedge clk);
         #1;
         chk({dv, rxd}, (m == 4) ? 9'h00B : 9'h105);
      end
      chk(crs, 1'b0);
   endtask : t_ddr

   task automatic t_carrier;
      tx_code <= 10'h100;
      wr(PMP_ADDR_CTRL, 32'h0000_0140);
      repeat (3) wait_on(1'b1);
      rx_act <= 1'b1;
      @(posedge clk);
      #1;
      chk(col, 1'b0);
      wr(PMP_ADDR_CTRL, 32'h0000_0100);
      chk(col, 1'b1);
      tx_code <= 10'h000;
      repeat (3) wait_on(1'b1);
      chk(crs, 1'b1);
      rx_act <= 1'b0;
      @(posedge clk);
      #1;
      chk(crs, 1'b0);
   endtask : t_carrier

   // ----------------------------------------------------------------
   // Sequence and watchdog
   // ----------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_modes();
      t_tx();
      t_rx();
      t_ddr();
      t_carrier();
      give_verdict();
   end

   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         mismatches++;
         give_verdict();
      end
   end
endmodule : testbench
